//--- verilog/adc_serial_channel_port.sv
`timescale 1ns/100ps
module adc_serial_channel_port
    import adc_port_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    input  wire logic        comp_in,
    output      logic        dout,
    output      logic        dout_oe,
    output      logic [3:0]  mux_channel,
    output      logic        track_mode,
    output      logic [11:0] dac_code,
    output      logic        span_double
);
    logic [3:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       din_s;
    logic       comp_s;

    // Chip select idles high, so its synchroniser resets to the idle level.
    pin_sync #(.WIDTH(4)) u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .pin_in    ({cs_n, sclk, din, comp_in}),
        .rst_value (4'h8),
        .pin_out   (pins_s)
    );
    assign cs_n_s = pins_s[3];
    assign sclk_s = pins_s[2];
    assign din_s  = pins_s[1];
    assign comp_s = pins_s[0];

    port_state_type state_reg,   state_next;
    logic [4:0]     falls_reg,   falls_next;
    logic [15:0]    shift_reg,   shift_next;
    logic [11:0]    cfg_reg,     cfg_next;
    logic [15:0]    list_reg,    list_next;
    logic           pend_reg,    pend_next;
    logic           load_reg,    load_next;
    logic [3:0]     chan_reg,    chan_next;
    logic [11:0]    sar_reg,     sar_next;
    logic           dout_reg,    dout_next;
    logic           track_reg,   track_next;
    logic           cs_prev_reg;
    logic           sclk_prev_reg;
    logic           cs_fall;
    logic           fall;

    assign cs_fall = cs_prev_reg & ~cs_n_s;
    assign fall    = sclk_prev_reg & ~sclk_s;

    function automatic logic [3:0] pick_channel(input logic [11:0] cfg,
                                                input logic [3:0]  cur,
                                                input logic [15:0] list);
        logic [3:0] addr;
        logic [3:0] probe;
        logic       found;
        addr  = cfg[CFG_ADDR_MSB_BIT:CFG_ADDR_LSB_BIT];
        probe = cur;
        found = 1'b0;
        pick_channel = addr;
        if (cfg[CFG_LIST_EN_BIT] && cfg[CFG_PATTERN_BIT]) begin
            // Walk channels 0..addr in turn.
            pick_channel = (cur >= addr) ? 4'h0 : 4'(cur + 4'h1);
        end else if (cfg[CFG_LIST_EN_BIT]) begin
            // Next listed channel after the current one; an empty list falls back to addr.
            for (int i = 1; i <= CHANNELS; i++) begin
                probe = 4'(cur + 4'(i));
                if (!found && list[probe]) begin
                    pick_channel = probe;
                    found = 1'b1;
                end
            end
        end
    endfunction : pick_channel

    always_comb begin
        int          k;
        int          b;
        logic [15:0] word;
        k          = int'(falls_reg) + 1;
        b          = 15 - k;
        word       = {shift_reg[14:0], din_s};
        state_next = state_reg;
        falls_next = falls_reg;
        shift_next = shift_reg;
        cfg_next   = cfg_reg;
        list_next  = list_reg;
        pend_next  = pend_reg;
        load_next  = load_reg;
        chan_next  = chan_reg;
        sar_next   = sar_reg;
        dout_next  = dout_reg;
        track_next = track_reg;
        if (cs_n_s) begin
            // A frame cut short by chip select applies nothing.
            state_next = ST_IDLE;
            falls_next = 5'h00;
            track_next = 1'b1;
        end else if (cs_fall) begin
            state_next = ST_FRAME;
            falls_next = 5'h00;
            track_next = 1'b0;
            load_next  = pend_reg;
            pend_next  = 1'b0;
            chan_next  = pend_reg ? cfg_reg[CFG_ADDR_MSB_BIT:CFG_ADDR_LSB_BIT]
                                  : pick_channel(cfg_reg, chan_reg, list_reg);
            dout_next  = chan_next[3];
        end else if (state_reg == ST_FRAME && fall) begin
            falls_next = 5'(k);
            shift_next = word;
            if (k <= ADDR_LAST_FALL) begin
                dout_next = chan_reg[3-k];
            end
            if (k == SAR_START_FALL) begin
                sar_next = SAR_START;
            end
            // The sixteenth fall carries no result bit, so the last bit keeps standing.
            if (k >= RESULT_FIRST_FALL && k < FRAME_BITS) begin
                sar_next[b] = comp_s;
                if (b > 0) begin
                    sar_next[b-1] = 1'b1;
                end
                // Twos complement only flips the result's top bit.
                dout_next = comp_s ^ (cfg_reg[CFG_CODING_BIT] && k == RESULT_FIRST_FALL);
            end
            if (k == TRACK_RETURN_FALL) begin
                track_next = 1'b1;
            end
            if (k == FRAME_BITS) begin
                state_next = ST_DONE;
                if (load_reg) begin
                    list_next = word;
                end else if (word[15]) begin
                    // Bits 15..4 are the first twelve captured; the rest are dropped.
                    cfg_next  = word[15:FRAME_BITS-CFG_BITS];
                    pend_next = !word[FRAME_BITS-1-(CFG_BITS-1-CFG_LIST_EN_BIT)]
                                && word[FRAME_BITS-CFG_BITS+CFG_PATTERN_BIT];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg     <= ST_IDLE;
            falls_reg     <= 5'h00;
            shift_reg     <= 16'h0000;
            cfg_reg       <= CFG_RESET;
            list_reg      <= LIST_RESET;
            pend_reg      <= 1'b0;
            load_reg      <= 1'b0;
            chan_reg      <= CHAN_RESET;
            sar_reg       <= 12'h000;
            dout_reg      <= 1'b0;
            track_reg     <= 1'b1;
            cs_prev_reg   <= 1'b1;
            sclk_prev_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            falls_reg     <= falls_next;
            shift_reg     <= shift_next;
            cfg_reg       <= cfg_next;
            list_reg      <= list_next;
            pend_reg      <= pend_next;
            load_reg      <= load_next;
            chan_reg      <= chan_next;
            sar_reg       <= sar_next;
            dout_reg      <= dout_next;
            track_reg     <= track_next;
            cs_prev_reg   <= cs_n_s;
            sclk_prev_reg <= sclk_s;
        end
    end

    assign dout        = dout_reg;
    assign dout_oe     = ~cs_n_s;
    assign mux_channel = chan_reg;
    assign track_mode  = track_reg;
    assign dac_code    = sar_reg;
    assign span_double = cfg_reg[CFG_RANGE_BIT];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_CS_FALL_HOLDS: assert property (
        cs_fall |=> (!track_mode && state_reg == ST_FRAME && falls_reg == 5'h00))
        else $error("Chip select fall did not start a conversion.");
    AST_FIXED_CHANNEL: assert property (
        (cs_fall && !cfg_reg[CFG_LIST_EN_BIT])
        |=> mux_channel == $past(cfg_reg[CFG_ADDR_MSB_BIT:CFG_ADDR_LSB_BIT]))
        else $error("Fixed channel differs from the address field.");
    AST_LIST_CHANNEL: assert property (
        (cs_fall && !pend_reg && cfg_reg[CFG_LIST_EN_BIT] && !cfg_reg[CFG_PATTERN_BIT]
         && list_reg != 16'h0000) |=> list_reg[mux_channel])
        else $error("Listed mode picked a channel not in the list.");
    AST_SPAN_STEADY: assert property (
        $changed(span_double) |-> $past(fall && falls_reg == 5'd15))
        else $error("Range changed outside the end of a frame.");
    AST_LIST_CAPTURE: assert property (
        (state_reg == ST_FRAME && fall && falls_reg == 5'd15 && load_reg && !cs_n_s)
        |=> list_reg[0] == $past(din_s))
        else $error("Last list bit not captured from the line.");
    AST_DOUT_ON_FALL: assert property (
        $changed(dout_reg) |-> $past(fall || cs_fall))
        else $error("Result output moved without a falling edge.");
    AST_ADDR_LSB_OUT: assert property (
        (state_reg == ST_FRAME && fall && falls_reg == 5'd2 && !cs_n_s)
        |=> dout == chan_reg[0])
        else $error("Fourth frame bit is not the channel lsb.");
    AST_CODING_MSB: assert property (
        (state_reg == ST_FRAME && fall && falls_reg == 5'd3 && !cs_n_s)
        |=> dout == ($past(comp_s) ^ cfg_reg[CFG_CODING_BIT]))
        else $error("Result msb coding is wrong.");
    AST_SAR_START: assert property (
        (state_reg == ST_FRAME && fall && falls_reg == 5'd2 && !cs_n_s)
        |=> dac_code == SAR_START)
        else $error("Trial code did not start at midscale.");
    AST_SIXTEEN_CLOCKS: assert property (
        state_reg == ST_DONE |-> falls_reg == 5'd16)
        else $error("Frame ended without sixteen clocks.");
    AST_CFG_NEXT_ONLY: assert property (
        $changed(cfg_reg) |-> $past(state_reg == ST_FRAME && falls_reg == 5'd15 && fall))
        else $error("Configuration changed inside a conversion.");
    AST_DOUT_RELEASED: assert property (
        dout_oe == !$past(cs_n, 2))
        else $error("Result output driven while deselected.");
endmodule : adc_serial_channel_port

//--- verilog/adc_port_pkg.sv
package adc_port_pkg;
    localparam int FRAME_BITS         = 16;
    localparam int CFG_BITS           = 12;
    localparam int RESULT_BITS        = 12;
    localparam int CHANNELS           = 16;
    // Configuration word layout, first bit on the line is bit 11.
    localparam int CFG_WRITE_BIT      = 11;
    localparam int CFG_LIST_EN_BIT    = 10;
    localparam int CFG_ADDR_MSB_BIT   = 9;
    localparam int CFG_ADDR_LSB_BIT   = 6;
    localparam int CFG_PATTERN_BIT    = 3;
    localparam int CFG_RANGE_BIT      = 1;
    localparam int CFG_CODING_BIT     = 0;
    // Falling-edge numbers inside a frame.
    localparam int ADDR_LAST_FALL     = 3;
    localparam int SAR_START_FALL     = 3;
    localparam int RESULT_FIRST_FALL  = 4;
    localparam int TRACK_RETURN_FALL  = 14;
    localparam int CFG_LAST_FALL      = 12;
    // Reset values, and the midscale trial start code.
    localparam logic [11:0] CFG_RESET  = 12'h000;
    localparam logic [15:0] LIST_RESET = 16'h0000;
    localparam logic [11:0] SAR_START  = 12'h800;
    localparam logic [3:0]  CHAN_RESET = 4'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_DONE} port_state_type;
endpackage : adc_port_pkg

//--- verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] rst_value,
    output      logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // Two flops only; the first stage feeds nothing but the second.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage1_reg <= rst_value;
            stage2_reg <= rst_value;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign pin_out = stage2_reg;
endmodule : pin_sync

//--- dv/host_master.sv
`timescale 1ns/100ps
module host_master (
    input  wire logic ref_clk,
    input  wire logic dout_w,
    input  wire logic track_mode,
    output      logic cs_n,
    output      logic sclk,
    output      logic din
);
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step

    // Falls sit eight ref_clk apart, so each synchronised edge settles before the next.
    // Fewer than sixteen falls cut the frame short on purpose.
    task automatic frame(input  logic [15:0] word,
                         input  int          nfall,
                         output logic [15:0] rd,
                         output logic [1:0]  th);
        cs_n = 1'b0;
        rd   = 'x;
        th   = 'x;
        step(4);
        for (int i = 15; i > 15 - nfall; i--) begin
            din = word[i];
            step(4);
            rd[i] = dout_w;
            if (i == 2) begin
                th[1] = track_mode;
            end
            sclk = 1'b0;
            step(4);
            sclk = 1'b1;
        end
        th[0] = track_mode;
        // The line is not held after the frame, so it shows the inverse of its last bit.
        din = ~din;
        step(4);
        cs_n = 1'b1;
        step(6);
    endtask : frame

    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        din  = 1'b0;
    end
endmodule : host_master

//--- dv/adc_serial_channel_port_tb_top.sv
`timescale 1ns/100ps
module adc_serial_channel_port_tb_top;
    import adc_port_pkg::*;
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        comp_in   = 1'b0;
    logic        cs_n, sclk, din, dout, dout_oe, track_mode, span_double;
    logic [3:0]  mux_channel;
    logic [11:0] dac_code;
    logic [15:0] rd;
    logic [1:0]  th;
    logic [3:0]  prev_ch;
    logic        prev_cod;
    int          err_count = 0;
    int          n_checks  = 0;
    int          cycles    = 0;
    wire         dout_w    = dout_oe ? dout : 1'bz;

    always #50 ref_clk = ~ref_clk;

    adc_serial_channel_port adc_serial_channel_port_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .din(din),
        .comp_in(comp_in), .dout(dout), .dout_oe(dout_oe), .mux_channel(mux_channel),
        .track_mode(track_mode), .dac_code(dac_code), .span_double(span_double));

    host_master host_master_inst (
        .ref_clk(ref_clk), .dout_w(dout_w), .track_mode(track_mode),
        .cs_n(cs_n), .sclk(sclk), .din(din));

    // Every channel gets its own level, so a wrong route shows in the result.
    function automatic logic [11:0] level(input logic [3:0] c);
        return {c, ~c, c ^ 4'h5};
    endfunction : level

    // Stands in for the analog comparator: high while the input is at or above the trial.
    always @(negedge ref_clk) comp_in <= (level(mux_channel) >= dac_code);

    // Low nibble is junk that must never reach the settings.
    function automatic logic [15:0] ctl(input logic wr, lst, pat, input logic [3:0] a,
                                        input logic rng, cod);
        return {wr, lst, a, 2'b00, pat, 1'b0, rng, cod, 4'ha};
    endfunction : ctl

    task automatic check(input logic [19:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic conv(input logic [15:0] w, input logic [3:0] ch, input logic cod);
        host_master_inst.frame(w, 16, rd, th);
        check(rd, {ch, level(ch) ^ {cod, 11'h000}});
        check(th, 2'b01);
        check(mux_channel, ch);
        check(dout_oe, 1'b0);
    endtask : conv

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // About thirty frames of some 140 cycles each; the ceiling leaves ample slack.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(negedge ref_clk);
        check({dout_oe, mux_channel, track_mode, dac_code, span_double},
              {1'b0, 4'h0, 1'b1, 12'h000, 1'b0});
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        prev_ch  = 4'h0;
        prev_cod = 1'b0;
        // Each frame reads back the previous frame's choice, never its own.
        for (int n = 0; n < 17; n++) begin
            conv(ctl(1'b1, 1'b0, 1'b0, n[3:0], n[0], n[1]), prev_ch, prev_cod);
            check(span_double, n[0]);
            prev_ch  = n[3:0];
            prev_cod = n[1];
        end
        host_master_inst.frame(ctl(1'b1, 1'b0, 1'b0, 4'h9, 1'b1, 1'b1), 8, rd, th);
        conv(ctl(1'b0, 1'b0, 1'b0, 4'h7, 1'b1, 1'b1), 4'h0, 1'b0);
        check(span_double, 1'b0);
        conv(ctl(1'b1, 1'b1, 1'b1, 4'h2, 1'b0, 1'b0), 4'h0, 1'b0);
        // The walk carries on from the channel last converted, which was 0.
        for (int k = 0; k < 4; k++) begin
            conv(ctl(1'b0, 1'b0, 1'b0, 4'hf, 1'b1, 1'b1), 4'((k + 1) % 3), 1'b0);
        end
        // Load a channel list, then step through its set bits from the current channel, 5.
        conv(ctl(1'b1, 1'b0, 1'b1, 4'h5, 1'b0, 1'b0), 4'h2, 1'b0);
        conv(16'h8421, 4'h5, 1'b0);
        conv(ctl(1'b1, 1'b1, 1'b0, 4'h3, 1'b0, 1'b0), 4'h5, 1'b0);
        for (int j = 0; j < 4; j++) begin
            conv(ctl(1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0), 4'(5 * ((j + 2) % 4)), 1'b0);
        end
        tally_and_finish();
    end
endmodule : adc_serial_channel_port_tb_top
